// ===== inc/asr_defs.svh
// shared constants of the serial converter link
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH
// ----------------------------------------
// data widths
// ----------------------------------------
`define ASR_RES_BITS 14
`define ASR_WORD_BITS 16
`define ASR_START_STROBE_N_STEPS 16
// ----------------------------------------
// conversion clock counts
// ----------------------------------------
`define ASR_CAL_CYCLES 14000
`define ASR_ACQ_CYCLES 4
`define ASR_START_LOW_CYC 2
`define ASR_M1_XFER_BITS 8
`define ASR_M1_XFERS 3
`define ASR_M1_FRAME_BITS (`ASR_M1_XFER_BITS * `ASR_M1_XFERS)
`define ASR_M1_WORD_MSB 20
`define ASR_M1_WORD_LSB 5
// ----------------------------------------
// core clock and derived rates
// ----------------------------------------
`define ASR_CORE_MHZ 100
`define ASR_START_STROBE_N_DIV 4
`define ASR_SER_KBPS 2500
`define ASR_SER_DIV ((`ASR_CORE_MHZ * 1000 + `ASR_SER_KBPS - 1) / `ASR_SER_KBPS)
`define ASR_MAX_START_STROBE_N_MS 20
`define ASR_MAX_START_STROBE_N_CYC (`ASR_MAX_START_STROBE_N_MS * `ASR_CORE_MHZ * 1000)
`define ASR_RST_HOLD_CYC 32
`endif

// ===== inc/asr_pkg.sv
// types shared by both ends of the converter link
package asr_pkg;
  typedef logic [13:0] asr_res_type;   // converted result
  typedef logic [15:0] asr_word_type;  // serial output word
  // device sequencer
  typedef enum logic [2:0] {
    DEV_CAL  = 3'b001,
    DEV_IDLE = 3'b010,
    DEV_START_STROBE_N = 3'b100
  } asr_dev_state_type;
  // host sequencer
  typedef enum logic [7:0] {
    H_RST   = 8'h01,
    H_CAL   = 8'h02,
    H_IDLE  = 8'h04,
    H_M1    = 8'h08,
    H_GAP   = 8'h10,
    H_WAIT2 = 8'h20,
    H_M2    = 8'h40,
    H_M2END = 8'h80
  } asr_host_state_type;
endpackage

// ===== inc/asr_link_if.sv
// pins between host and converter
`timescale 1ns/1ps
interface asr_link_if;
  logic convClk;    // conversion clock, made by host
  logic serClk;     // serial clock, idle low
  logic resetPinN;  // device reset, active low
  logic startN;     // start strobe, active low
  logic rangeSel;   // range / sleep select
  logic csN;        // chip select, active low
  logic serOut;     // device data drive value
  logic serOutEn;   // device data drive enable
  logic doneN;      // conversion done, active low
  logic serLine;    // resolved data wire
  // released line floats high
  assign serLine = serOutEn ? serOut : 1'b1;
  modport host (
    output convClk, serClk, resetPinN, startN, rangeSel, csN,
    input  doneN, serLine
  );
  modport dev (
    input  convClk, serClk, resetPinN, startN, rangeSel, csN,
    output serOut, serOutEn, doneN
  );
endinterface

// ===== hdl/asr_dev.sv
// converter end: calibration, conversion and serial output
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_dev #(
  parameter int unsigned CAL_CYCLES = `ASR_CAL_CYCLES
) (
  asr_link_if.dev              link,
  input  asr_pkg::asr_res_type sampleValue,
  output asr_pkg::asr_res_type lastResult,
  output logic                 converting
);
  import asr_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic              rstS1_q, rstS2_q;      // reset pin sync
  logic              startS1_q, startS2_q;  // start strobe sync
  logic              csS1_q, csS2_q;        // chip select sync
  logic              sclkS1_q, sclkS2_q;    // serial clock sync
  logic              sclkS3_q;              // edge history
  logic              rangeS1_q, rangeS2_q;  // range select sync
  asr_res_type       sampS1_q, sampS2_q;    // sample sync
  asr_dev_state_type state_q;               // sequencer state
  logic [31:0]       calCnt_q;              // calibration count
  logic [2:0]        acqCnt_q;              // edges since end
  logic              pend_q;                // start waits for acquisition
  logic [4:0]        step_q;                // conversion step
  asr_res_type       held_q;                // held sample
  asr_res_type       res_q;                 // decided bits
  logic              bip_q;                 // bipolar coding
  asr_word_type      shift_q;               // readout shift
  logic              doneN_q, serOut_q, serOutEn_q;
  asr_res_type       lastResult_q;
  logic              converting_q;
  logic              sclkFall;
  logic              canStart;
  logic [3:0]        bitIdx;

  // one trial of successive approximation
  function automatic logic sarDecide(input asr_res_type held, input asr_res_type res,
                                     input logic [3:0] idx);
    asr_res_type trial;
    trial = res | (asr_res_type'(1) << idx);
    return held >= trial;
  endfunction

  assign sclkFall = sclkS3_q & ~sclkS2_q;
  assign canStart = acqCnt_q >= 3'(`ASR_ACQ_CYCLES - 1);
  assign bitIdx   = 4'(`ASR_RES_BITS - 1) - step_q[3:0];

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // everything faces the link clock falling edge
  always_ff @(negedge link.convClk) begin
    rstS1_q   <= link.resetPinN;
    rstS2_q   <= rstS1_q;
    startS1_q <= link.startN;
    startS2_q <= startS1_q;
    csS1_q    <= link.csN;
    csS2_q    <= csS1_q;
    sclkS1_q  <= link.serClk;
    sclkS2_q  <= sclkS1_q;
    sclkS3_q  <= sclkS2_q;
    rangeS1_q <= link.rangeSel;
    rangeS2_q <= rangeS1_q;
    sampS1_q  <= sampleValue;
    sampS2_q  <= sampS1_q;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // calibration, acquisition wait, bit decisions
  always_ff @(negedge link.convClk) begin
    if (!rstS2_q) begin
      state_q      <= DEV_CAL;
      calCnt_q     <= 32'h0;
      acqCnt_q     <= 3'h0;
      pend_q       <= 1'b0;
      step_q       <= 5'h0;
      held_q       <= '0;
      res_q        <= '0;
      bip_q        <= 1'b0;
      doneN_q      <= 1'b1;  // high while reset held
      serOut_q     <= 1'b0;
      shift_q      <= '0;
      lastResult_q <= '0;
      converting_q <= 1'b0;
    end else begin
      case (state_q)
        DEV_CAL: begin
          // count link clocks after reset release
          if (calCnt_q == CAL_CYCLES - 1) begin
            state_q  <= DEV_IDLE;
            doneN_q  <= 1'b0;  // calibration finished
            acqCnt_q <= 3'(`ASR_ACQ_CYCLES);
          end else begin
            calCnt_q <= calCnt_q + 32'h1;
          end
        end
        DEV_IDLE: begin
          // saturating acquisition counter
          if (acqCnt_q < 3'(`ASR_ACQ_CYCLES)) begin
            acqCnt_q <= acqCnt_q + 3'h1;
          end
          if ((!startS2_q || pend_q) && canStart) begin
            // begin conversion on this falling edge
            state_q      <= DEV_START_STROBE_N;
            pend_q       <= 1'b0;
            held_q       <= sampS2_q;
            bip_q        <= ~rangeS2_q;
            step_q       <= 5'h1;
            doneN_q      <= 1'b1;
            converting_q <= 1'b1;
            res_q        <= {sarDecide(sampS2_q, '0, 4'hd), 13'h0};
            serOut_q     <= sarDecide(sampS2_q, '0, 4'hd) ^ ~rangeS2_q;
          end else if (!startS2_q) begin
            pend_q <= 1'b1;  // hold off until fourth edge
          end else if (sclkFall && !csS2_q) begin
            // between conversions shift on serial clock fall
            shift_q  <= {shift_q[14:0], 1'b0};
            serOut_q <= shift_q[14];
          end
        end
        DEV_START_STROBE_N: begin
          // link clock times conversion, serial clock ignored
          if (step_q == 5'(`ASR_START_STROBE_N_STEPS)) begin
            state_q      <= DEV_IDLE;
            acqCnt_q     <= 3'h0;
            doneN_q      <= 1'b0;  // result ready
            converting_q <= 1'b0;
            shift_q      <= {res_q[13] ^ bip_q, res_q[12:0], 2'b00};
            serOut_q     <= res_q[13] ^ bip_q;
            lastResult_q <= {res_q[13] ^ bip_q, res_q[12:0]};
          end else begin
            step_q <= step_q + 5'h1;
            if (step_q < 5'(`ASR_RES_BITS)) begin
              // each bit leaves as soon as decided
              res_q[bitIdx] <= sarDecide(held_q, res_q, bitIdx);
              serOut_q      <= sarDecide(held_q, res_q, bitIdx);
            end else begin
              serOut_q <= 1'b0;  // pad bits of the word
            end
          end
        end
        default: state_q <= DEV_CAL;
      endcase
    end
  end

  // ----------------------------------------
  // output enable
  // ----------------------------------------
  // drive data only while selected
  always_ff @(negedge link.convClk) begin
    if (!rstS2_q) begin
      serOutEn_q <= 1'b0;
    end else begin
      serOutEn_q <= ~csS2_q;
    end
  end

  assign link.doneN    = doneN_q;
  assign link.serOut   = serOut_q;
  assign link.serOutEn = serOutEn_q;
  assign lastResult    = lastResult_q;
  assign converting    = converting_q;
endmodule  // asr_dev

// ===== hdl/asr_host.sv
// host end: clocks, reset, start and result readout
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_host #(
  parameter int unsigned WAIT_LIMIT = `ASR_MAX_START_STROBE_N_CYC
) (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic            modeSel,
  input  wire logic            rangeSel,
  input  wire logic            convReq,
  output asr_pkg::asr_res_type resultData,
  output logic                 resultValid,
  output logic                 busy,
  output logic                 calDone,
  output logic                 timeoutErr,
  asr_link_if.host             link
);
  import asr_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [7:0] START_STROBE_N_HALF = 8'(`ASR_START_STROBE_N_DIV / 2);
  localparam logic [7:0] SER_HALF  = 8'(`ASR_SER_DIV / 2);

  asr_host_state_type state_q;          // sequencer state
  logic [7:0]   convDiv_q;              // conversion clock divider
  logic         convClk_q;              // conversion clock
  logic [7:0]   serDiv_q;               // serial clock divider
  logic         serClk_q;               // serial clock
  logic         doneS1_q, doneS2_q;     // done sync
  logic         serS1_q, serS2_q;       // data sync
  logic [1:0]   lowCnt_q;               // start low periods
  logic [4:0]   bitCnt_q;               // bits taken
  logic [2:0]   gapCnt_q;               // idle periods after frame
  logic [31:0]  waitCnt_q;              // wait watchdog
  logic         seenHigh_q;             // done went high
  logic [23:0]  cap_q;                  // captured bits
  logic         resetPinN_q, startN_q, rangeSel_q, csN_q;
  asr_res_type  result_q;
  logic         valid_q, busy_q, calDone_q, tmo_q;
  logic         convTick, convRise, convFall;
  logic         serRun, serTick, serRise, serFall;
  logic         waitOver;
  logic [23:0]  capNext;

  // divider half period reached
  function automatic logic halfDone(input logic [7:0] cnt, input logic [7:0] half);
    return cnt == half - 8'h01;
  endfunction

  assign convTick = halfDone(convDiv_q, START_STROBE_N_HALF);
  assign convRise = convTick & ~convClk_q;
  assign convFall = convTick & convClk_q;
  assign serRun   = (state_q == H_M2) || (state_q == H_M2END);
  assign serTick  = halfDone(serDiv_q, SER_HALF);
  assign serRise  = serTick & ~serClk_q;
  assign serFall  = serTick & serClk_q;
  assign waitOver = waitCnt_q >= WAIT_LIMIT;
  assign capNext  = {cap_q[22:0], serS2_q};

  // ----------------------------------------
  // clock generation
  // ----------------------------------------
  // free-running conversion clock, also through calibration
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      convDiv_q <= 8'h0;
      convClk_q <= 1'b0;
    end else if (convTick) begin
      convDiv_q <= 8'h0;
      convClk_q <= ~convClk_q;
    end else begin
      convDiv_q <= convDiv_q + 8'h1;
    end
  end

  // serial clock runs only for a mode 2 readout
  always_ff @(posedge core_clk) begin
    if (!rst_n || !serRun) begin
      serDiv_q <= 8'h0;
      serClk_q <= 1'b0;
    end else if (serTick) begin
      serDiv_q <= 8'h0;
      serClk_q <= ~serClk_q;
    end else begin
      serDiv_q <= serDiv_q + 8'h1;
    end
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    doneS1_q <= link.doneN;
    doneS2_q <= doneS1_q;
    serS1_q  <= link.serLine;
    serS2_q  <= serS1_q;
  end

  // range pin follows the user, high out of reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rangeSel_q <= 1'b1;
    end else begin
      rangeSel_q <= rangeSel;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q     <= H_RST;
      resetPinN_q <= 1'b1;
      startN_q    <= 1'b1;
      csN_q       <= 1'b1;
      lowCnt_q    <= 2'h0;
      bitCnt_q    <= 5'h0;
      gapCnt_q    <= 3'h0;
      waitCnt_q   <= 32'h0;
      seenHigh_q  <= 1'b0;
      cap_q       <= 24'h0;
      result_q    <= '0;
      valid_q     <= 1'b0;
      busy_q      <= 1'b1;
      calDone_q   <= 1'b0;
      tmo_q       <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      tmo_q   <= 1'b0;
      // start held low for two conversion periods
      if (!startN_q && convRise) begin
        if (lowCnt_q == 2'(`ASR_START_LOW_CYC - 1)) begin
          startN_q <= 1'b1;
        end else begin
          lowCnt_q <= lowCnt_q + 2'h1;
        end
      end
      case (state_q)
        H_RST: begin
          // reset low for a minimum hold, then until done reads high
          resetPinN_q <= 1'b0;
          busy_q      <= 1'b1;
          calDone_q   <= 1'b0;
          waitCnt_q   <= waitCnt_q + 32'h1;
          if (doneS2_q && waitCnt_q >= 32'(`ASR_RST_HOLD_CYC)) begin
            state_q     <= H_CAL;
            resetPinN_q <= 1'b1;
            waitCnt_q   <= 32'h0;
          end
        end
        H_CAL: begin
          // watch done for end of calibration
          waitCnt_q <= waitCnt_q + 32'h1;
          if (!doneS2_q) begin
            state_q   <= H_IDLE;
            calDone_q <= 1'b1;
            busy_q    <= 1'b0;
          end else if (waitOver) begin
            state_q   <= H_RST;
            tmo_q     <= 1'b1;
            waitCnt_q <= 32'h0;  // restart the reset hold
          end
        end
        H_IDLE: begin
          // accept only when no conversion runs
          if (convReq && !doneS2_q && convRise) begin
            startN_q   <= 1'b0;  // changes with the clock rise
            lowCnt_q   <= 2'h0;
            bitCnt_q   <= 5'h0;
            waitCnt_q  <= 32'h0;
            seenHigh_q <= 1'b0;
            busy_q     <= 1'b1;
            if (modeSel) begin
              state_q <= H_WAIT2;
            end else begin
              state_q <= H_M1;
              csN_q   <= 1'b0;
            end
          end
        end
        H_M1: begin
          // three byte frames back to back, taken on falls
          if (convFall) begin
            cap_q    <= capNext;
            bitCnt_q <= bitCnt_q + 5'h1;
            if (bitCnt_q == 5'(`ASR_M1_FRAME_BITS - 1)) begin
              result_q <= capNext[`ASR_M1_WORD_MSB:`ASR_M1_WORD_LSB + 2];
              valid_q  <= 1'b1;
              csN_q    <= 1'b1;
              gapCnt_q <= 3'h0;
              state_q  <= H_GAP;  // frame has no pauses
            end
          end
        end
        H_GAP: begin
          // let acquisition time pass before next start
          if (convRise) begin
            gapCnt_q <= gapCnt_q + 3'h1;
            if (gapCnt_q == 3'(`ASR_ACQ_CYCLES - 1)) begin
              state_q <= H_IDLE;
              busy_q  <= 1'b0;
            end
          end
        end
        H_WAIT2: begin
          // done high then low marks a fresh result
          waitCnt_q <= waitCnt_q + 32'h1;
          if (doneS2_q) begin
            seenHigh_q <= 1'b1;
          end
          if (seenHigh_q && !doneS2_q && startN_q) begin
            state_q  <= H_M2;
            csN_q    <= 1'b0;
            bitCnt_q <= 5'h0;
          end else if (waitOver) begin
            state_q <= H_IDLE;  // bounded wait
            busy_q  <= 1'b0;
            tmo_q   <= 1'b1;
          end
        end
        H_M2: begin
          // one 16-bit transfer; rate kept at 2.5 Mbps so rises are safe
          if (serRise) begin
            cap_q    <= capNext;
            bitCnt_q <= bitCnt_q + 5'h1;
            if (bitCnt_q == 5'(`ASR_WORD_BITS - 1)) begin
              result_q <= capNext[15:2];
              valid_q  <= 1'b1;
              state_q  <= H_M2END;
            end
          end
        end
        H_M2END: begin
          // finish on the clock fall, leaving it low
          if (serFall) begin
            csN_q   <= 1'b1;
            state_q <= H_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: state_q <= H_RST;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.convClk   = convClk_q;
  assign link.serClk    = serClk_q;
  assign link.resetPinN = resetPinN_q;
  assign link.startN    = startN_q;
  assign link.rangeSel  = rangeSel_q;
  assign link.csN       = csN_q;
  assign resultData     = result_q;
  assign resultValid    = valid_q;
  assign busy           = busy_q;
  assign calDone        = calDone_q;
  assign timeoutErr     = tmo_q;
endmodule  // asr_host

// ===== tb/asr_link_properties.sv
// concurrent checks on the converter link pins
`timescale 1ns/1ps
module asr_link_properties #(
  parameter int unsigned CAL_CYCLES = 14000
) (
  input wire logic convClk,
  input wire logic serClk,
  input wire logic resetPinN,
  input wire logic startN,
  input wire logic csN,
  input wire logic serOut,
  input wire logic serOutEn,
  input wire logic doneN
);
  // ----------------------------------------
  // calibration tracking
  // ----------------------------------------
  logic        calOn_q;   // calibration still running
  int unsigned calCnt_q;  // falls since reset pin release
  default clocking cb @(negedge convClk); endclocking
  default disable iff (!resetPinN);
  // set by the reset pin, cleared once done drops
  always_ff @(negedge convClk) begin
    if (!resetPinN) begin
      calOn_q <= 1'b1;
    end else if (!doneN) begin
      calOn_q <= 1'b0;
    end
  end
  // counts falls while calibrating
  always_ff @(negedge convClk) begin
    if (!resetPinN) begin
      calCnt_q <= 0;
    end else if (calOn_q) begin
      calCnt_q <= calCnt_q + 1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  serclk_idle_a : assert property (
    csN |-> !serClk) else $error("serial clock high while deselected");
  serclk_start_strobe_n_a : assert property (
    !csN && doneN |-> !serClk) else $error("serial clock high during conversion");
  start_width_a : assert property (
    $fell(startN) |=> !startN) else $error("start strobe too short");
  start_strobe_n_start_a : assert property (
    $fell(startN) && !doneN |-> ##[1:8] doneN) else $error("conversion did not begin");
  start_strobe_n_len_a : assert property (
    $rose(doneN) |-> doneN [*8] ##1 doneN [*8] ##1 !doneN)
    else $error("conversion length wrong");
  csn_release_a : assert property (
    csN && $past(csN) && $past(csN, 2) && $past(csN, 3) |-> !serOutEn)
    else $error("data driven while deselected");
  shift_edge_a : assert property (
    !csN && !doneN && $changed(serOut) |-> !serClk) else $error("data moved off fall");
  reset_done_a : assert property (disable iff (1'b0)
    !resetPinN [*4] |-> doneN) else $error("done low while reset held");
  cal_min_a : assert property (
    $fell(doneN) && calOn_q |-> calCnt_q >= CAL_CYCLES) else $error("calibration short");
  cal_max_a : assert property (
    calOn_q |-> calCnt_q <= CAL_CYCLES + 8) else $error("calibration overran");
endmodule // asr_link_properties

// ===== tb/tb_top.sv
// self-checking bench joining host and converter ends
`timescale 1ns/1ps
module tb_top;
  import asr_pkg::*;
  localparam int unsigned CAL_SIM  = 50;     // shortened calibration
  localparam int unsigned WAIT_SIM = 2000;   // shortened calibration and readout wait
  localparam int          LIMIT    = 40000;  // run ceiling in core cycles
  logic        core_clk;     // core clock
  logic        rst_n;        // host reset
  logic        modeSel;      // 0 mode 1, 1 mode 2
  logic        rangeSel;     // low bipolar
  logic        convReq;      // conversion request
  asr_res_type resultData;   // host result
  logic        resultValid;  // result pulse
  logic        busy;         // host busy
  logic        calDone;      // calibration done
  logic        timeoutErr;   // calibration or readout wait expired
  asr_res_type sampleValue;  // analog stand-in
  asr_res_type lastResult;   // device result
  logic        converting;   // device converting
  asr_res_type expQ[$];      // expected results
  int          errTotal;     // mismatches
  int          testsRun;     // comparisons
  int          cycles;       // run length
  asr_res_type expV;         // oldest expected result
  asr_link_if link ();
  asr_host #(.WAIT_LIMIT(WAIT_SIM)) i_asr_host (
    .core_clk(core_clk), .rst_n(rst_n), .modeSel(modeSel), .rangeSel(rangeSel),
    .convReq(convReq), .resultData(resultData), .resultValid(resultValid), .busy(busy),
    .calDone(calDone), .timeoutErr(timeoutErr), .link(link));
  asr_dev #(.CAL_CYCLES(CAL_SIM)) i_asr_dev (
    .link(link), .sampleValue(sampleValue), .lastResult(lastResult),
    .converting(converting));
  asr_link_properties #(.CAL_CYCLES(CAL_SIM)) i_asr_link_properties (
    .convClk(link.convClk), .serClk(link.serClk), .resetPinN(link.resetPinN),
    .startN(link.startN), .csN(link.csN), .serOut(link.serOut),
    .serOutEn(link.serOutEn), .doneN(link.doneN));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always #5 core_clk = ~core_clk;
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // picks the flag that a wait watches
  function automatic logic probe(input int k);
    case (k)
      0: return busy;
      1: return calDone;
      default: return link.doneN;
    endcase
  endfunction
  // bounded wait for a flag level
  task automatic wait_on(input int k, input logic val);
    int n;
    n = 0;
    while (probe(k) !== val && n < 3000) begin
      tick();
      n++;
    end
    check("flag wait", 14'(probe(k)), 14'(val));
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (6) tick();
    expQ.delete();
    check("resetPinN idle", 14'(link.resetPinN), 14'h0001);
    check("startN idle", 14'(link.startN), 14'h0001);
    check("rangeSel idle", 14'(link.rangeSel), 14'h0001);
    check("serClk idle", 14'(link.serClk), 14'h0000);
    rst_n = 1'b1;
    repeat (2) tick();
    check("reset pin low", 14'(link.resetPinN), 14'h0000);
    wait_on(2, 1'b1);
    wait_on(1, 1'b1);
    check("done after cal", 14'(link.doneN), 14'h0000);
  endtask
  // one conversion, expectation noted first
  task automatic convert(input logic m, input logic r, input asr_res_type v);
    wait_on(0, 1'b0);
    sampleValue = v;
    modeSel = m;
    rangeSel = r;
    repeat (12) tick();
    expQ.push_back(r ? v : v ^ 14'h2000);
    convReq = 1'b1;
    wait_on(0, 1'b1);
    convReq = 1'b0;
    repeat (16) tick();
    check("converting", 14'(converting), 14'h0001);
    wait_on(0, 1'b0);
    check("converting idle", 14'(converting), 14'h0000);
  endtask
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------
  // result monitor and run ceiling
  // ----------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (resultValid === 1'b1) begin
      if (expQ.size() == 0) begin
        errTotal++;
        $display("Error resultData expected none seen %h", resultData);
      end else begin
        expV = expQ.pop_front();
        check("resultData", resultData, expV);
        check("lastResult", lastResult, expV);
      end
    end
    if (timeoutErr === 1'b1) begin
      errTotal++;
      $display("Error timeoutErr expected 0 seen 1");
    end
    if (cycles == LIMIT) begin
      errTotal++;
      stopTest();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    modeSel = 1'b0;
    rangeSel = 1'b1;
    convReq = 1'b0;
    sampleValue = 14'h0000;
    errTotal = 0;
    testsRun = 0;
    cycles = 0;
    void'($urandom(84994));
    do_reset();
    $display("test reset done");
    // every mode and range, edge values then random
    for (int i = 0; i < 8; i++) begin
      convert(i[0], i[1], i[2] ? asr_res_type'($urandom) : (i[1] ? 14'h3fff : 14'h0000));
    end
    $display("test modes done");
    // back-to-back random requests
    repeat (4) begin
      convert(1'($urandom_range(1)), 1'($urandom_range(1)), asr_res_type'($urandom));
    end
    $display("test burst done");
    // host reset in mid mode 2 readout, then recover
    sampleValue = 14'h1555;
    modeSel = 1'b1;
    repeat (12) tick();
    convReq = 1'b1;
    wait_on(0, 1'b1);
    convReq = 1'b0;
    repeat (300) tick();
    do_reset();
    convert(1'b0, 1'b1, 14'h2aaa);
    $display("test abort done");
    repeat (20) tick();
    stopTest();
  end
endmodule // tb_top
